//--- verification/float_arith_datapath_bench.sv
// Self-checking bench for the floating point datapath
// Controls change at the falling edge; the feeder drives the buses
`timescale 1ns/1ps
module float_arith_datapath_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] rWord = 32'h0000_0000;
  logic [31:0] sWord = 32'h0000_0000;
  logic [31:0] rBus, sBus, fBus;
  logic [2:0] opcode = 3'h0;
  logic [2:0] roundMode = 3'h0;
  logic [1:0] ioMode = 2'h0;
  logic altFormat = 1'b0, rEnable = 1'b1, sEnable = 1'b1, fEnable = 1'b1;
  logic rTransparent = 1'b0, sTransparent = 1'b0, fTransparent = 1'b0;
  logic rSelectResult = 1'b0, sSelectF = 1'b0, fOutputEnable = 1'b0;
  logic fBusEn, halfPhase;
  logic [5:0] statusFlags;
  logic [31:0] rndExp [4];
  int err_total = 0;
  int compares = 0;
  // Clock and design under test
  always #25 core_clk = ~core_clk;
  operand_feeder feed (.core_clk(core_clk), .ioMode(ioMode), .halfPhase(halfPhase),
    .rWord(rWord), .sWord(sWord), .rBus(rBus), .sBus(sBus));
  float_arith_datapath DUT (.core_clk(core_clk), .reset(reset), .rBus(rBus), .sBus(sBus),
    .opcode(opcode), .roundMode(roundMode), .altFormat(altFormat), .ioMode(ioMode),
    .rEnable(rEnable), .sEnable(sEnable), .fEnable(fEnable), .rTransparent(rTransparent),
    .sTransparent(sTransparent), .fTransparent(fTransparent), .rSelectResult(rSelectResult),
    .sSelectF(sSelectF), .fOutputEnable(fOutputEnable), .fBus(fBus), .fBusEn(fBusEn),
    .statusFlags(statusFlags), .halfPhase(halfPhase));
  // Compare one value with its expectation
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Dual mode operation: operands load, then result loads
  task run(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] ef, input logic [5:0] efl);
    opcode = op;
    rWord = a;
    sWord = b;
    step(2);
    check(fBus, ef);
    check(32'(statusFlags), 32'(efl));
  endtask
  // Bounded wait for a slot phase
  task await_phase(input logic v);
    int n;
    n = 0;
    while (halfPhase !== v && n < 4)
    begin
      step(1);
      n++;
    end
    if (halfPhase !== v)
    begin
      err_total++;
      complete_run();
    end
  endtask
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rndExp = '{32'h3F80_0000, 32'h3F80_0000, 32'h3F80_0001, 32'h3F80_0000};
    step(10);
    reset = 1'b0;
    run(float_arith_pkg::OP_ADD, 32'h3F80_0000, 32'h4000_0000, 32'h4040_0000, 6'h00);
    run(float_arith_pkg::OP_SUB, 32'h3F80_0000, 32'h4000_0000, 32'hBF80_0000, 6'h00);
    run(float_arith_pkg::OP_SUB, 32'h3F80_0000, 32'h3F80_0000, 32'h0000_0000, 6'h02);
    run(float_arith_pkg::OP_MUL, 32'h4000_0000, 32'h4040_0000, 32'h40C0_0000, 6'h00);
    run(float_arith_pkg::OP_TWO_MINUS, 32'h0000_0000, 32'h3F00_0000, 32'h3FC0_0000, 6'h00);
    run(float_arith_pkg::OP_INTEGER_TO_FLOAT, 32'h0000_0007, 32'h0000_0000, 32'h40E0_0000, 6'h00);
    run(float_arith_pkg::OP_FLOAT_TO_INTEGER, 32'h4040_0000, 32'h0000_0000, 32'h0000_0003, 6'h00);
    $display("arithmetic test done");
    run(float_arith_pkg::OP_MUL, 32'h7F80_0000, 32'h0000_0000, 32'h7FC0_0000, 6'h21);
    run(float_arith_pkg::OP_MUL, 32'h7F00_0000, 32'h7F00_0000, 32'h7F80_0000, 6'h0C);
    run(float_arith_pkg::OP_MUL, 32'h0080_0000, 32'h0080_0000, 32'h0000_0000, 6'h16);
    for (int i = 0; i < 4; i++)
    begin
      roundMode = 3'(i);
      run(float_arith_pkg::OP_ADD, 32'h3F80_0000, 32'h3080_0000, rndExp[i], 6'h04);
    end
    roundMode = float_arith_pkg::RND_NEAREST_EVEN;
    $display("exception test done");
    run(float_arith_pkg::OP_STD_TO_ALT_FORMAT, 32'h3F80_0000, 32'h0, 32'h4080_0000, 6'h00);
    run(float_arith_pkg::OP_ALT_TO_STD_FORMAT, 32'h4080_0000, 32'h0, 32'h3F80_0000, 6'h00);
    altFormat = 1'b1;
    roundMode = float_arith_pkg::RND_ALT_HALF_AWAY;
    run(float_arith_pkg::OP_ADD, 32'h4080_0000, 32'h4080_0000, 32'h4100_0000, 6'h00);
    altFormat = 1'b0;
    roundMode = float_arith_pkg::RND_NEAREST_EVEN;
    $display("format test done");
    run(float_arith_pkg::OP_ADD, 32'h3F80_0000, 32'h4000_0000, 32'h4040_0000, 6'h00);
    fEnable = 1'b0;
    rWord = 32'h4000_0000;
    step(2);
    check(fBus, 32'h4040_0000);
    check(32'(statusFlags), 32'h0000_0000);
    fEnable = 1'b1;
    fOutputEnable = 1'b1;
    #5 check(32'(fBusEn), 32'h0000_0000);
    step(1);
    check(32'(fBusEn), 32'h0000_0001);
    fOutputEnable = 1'b0;
    run(float_arith_pkg::OP_ADD, 32'h3F80_0000, 32'h4000_0000, 32'h4040_0000, 6'h00);
    rEnable = 1'b0;
    rWord = 32'h4000_0000;
    step(2);
    check(fBus, 32'h4040_0000);
    rEnable = 1'b1;
    rWord = 32'h3F80_0000;
    rSelectResult = 1'b1;
    step(1);
    rSelectResult = 1'b0;
    step(1);
    check(fBus, 32'h40A0_0000);
    opcode = float_arith_pkg::OP_MUL;
    rWord = 32'h4000_0000;
    sSelectF = 1'b1;
    step(2);
    check(fBus, 32'h4120_0000);
    sSelectF = 1'b0;
    {rTransparent, sTransparent, fTransparent} = 3'h7;
    opcode = float_arith_pkg::OP_ADD;
    rWord = 32'h3F80_0000;
    #10 check(fBus, 32'h4040_0000);
    step(1);
    rWord = 32'h4000_0000;
    #10 check(fBus, 32'h4080_0000);
    step(1);
    {rTransparent, sTransparent, fTransparent} = 3'h0;
    $display("datapath test done");
    ioMode = float_arith_pkg::IO_SINGLE32;
    opcode = float_arith_pkg::OP_SUB;
    rWord = 32'h4040_0000;
    sWord = 32'h3F80_0000;
    step(6);
    check(fBus, 32'h4000_0000);
    $display("single bus test done");
    ioMode = float_arith_pkg::IO_HALF16;
    opcode = float_arith_pkg::OP_MUL;
    rWord = 32'h3F80_0001;
    sWord = 32'h4000_0000;
    step(8);
    await_phase(1'b1);
    check(fBus, 32'h0000_4000);
    step(1);
    check(fBus, 32'h0000_0001);
    ioMode = float_arith_pkg::IO_DUAL32;
    step(3);
    $display("half bus test done");
    complete_run();
  end
endmodule

//--- verification/float_arith_monitor.sv
// Port assertions for the floating point datapath
// Bound to the datapath top; single clock, synchronous reset
`timescale 1ns/1ps
module float_arith_monitor (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [1:0] ioMode,
  input wire logic fEnable,
  input wire logic fTransparent,
  input wire logic fOutputEnable,
  input wire logic [31:0] fBus,
  input wire logic fBusEn,
  input wire logic [5:0] statusFlags,
  input wire logic halfPhase
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // F register idle, then still shown directly
  sequence f_idle;
    !reset && !fEnable && !fTransparent && ioMode == float_arith_pkg::IO_DUAL32;
  endsequence
  sequence f_shown;
    !fTransparent && ioMode == float_arith_pkg::IO_DUAL32;
  endsequence
  // Buses shared over two slots
  sequence muxed;
    ioMode == float_arith_pkg::IO_SINGLE32 || ioMode == float_arith_pkg::IO_HALF16;
  endsequence
  oe_delay_a: assert property (!$past(reset) |-> fBusEn == $past(fOutputEnable))
    else $error("bus enable not one cycle after request");
  f_hold_a: assert property (f_idle ##1 f_shown |-> $stable(fBus) && $stable(statusFlags))
    else $error("result or flags moved without enable");
  zero_flag_a: assert property (statusFlags[float_arith_pkg::FLAG_ZERO] && ioMode == float_arith_pkg::IO_DUAL32
    |-> fBus[30:0] == 31'h0)
    else $error("zero flag with nonzero result");
  nan_flag_a: assert property (statusFlags[float_arith_pkg::FLAG_NOT_NUMERIC]
    && ioMode == float_arith_pkg::IO_DUAL32 |-> fBus[30:23] == 8'hFF || fBus == float_arith_pkg::ALT_RESERVED)
    else $error("not numeric flag with numeric result");
  phase_swap_a: assert property (muxed ##1 muxed |-> halfPhase != $past(halfPhase))
    else $error("slot phase did not alternate");
  dual_phase_a: assert property ((ioMode == float_arith_pkg::IO_DUAL32) [*2] |-> halfPhase)
    else $error("slot phase low in dual mode");
  half_upper_a: assert property (ioMode == float_arith_pkg::IO_HALF16 |-> fBus[31:16] == 16'h0000)
    else $error("upper bus bits driven in half mode");
  reset_state_a: assert property ($past(reset) && !fTransparent |->
    !fBusEn && halfPhase && statusFlags == 6'h00 && fBus == 32'h0000_0000)
    else $error("wrong state after reset");
endmodule
bind float_arith_datapath float_arith_monitor mon (
  .core_clk(core_clk), .reset(reset), .ioMode(ioMode), .fEnable(fEnable),
  .fTransparent(fTransparent), .fOutputEnable(fOutputEnable), .fBus(fBus),
  .fBusEn(fBusEn), .statusFlags(statusFlags), .halfPhase(halfPhase));

//--- verification/operand_feeder.sv
// Controller-side operand source for the datapath buses
// Drives shortly after each falling edge; follows the slot phase
`timescale 1ns/1ps
module operand_feeder (
  input wire logic core_clk,
  input wire logic [1:0] ioMode,
  input wire logic halfPhase,
  input wire logic [31:0] rWord,
  input wire logic [31:0] sWord,
  output logic [31:0] rBus,
  output logic [31:0] sBus
);
  initial
  begin
    rBus = 32'h0000_0000;
    sBus = 32'h0000_0000;
  end
  // Lay the words out as the bus mode wants; unused lines toggle
  always @(negedge core_clk)
  begin
    #2;
    case (ioMode)
      float_arith_pkg::IO_SINGLE32:
      begin
        rBus = halfPhase ? sWord : rWord;
        sBus = ~sBus;
      end
      float_arith_pkg::IO_HALF16:
      begin
        rBus = {~rBus[31:16], halfPhase ? rWord[31:16] : rWord[15:0]};
        sBus = {~sBus[31:16], halfPhase ? sWord[31:16] : sWord[15:0]};
      end
      default:
      begin
        rBus = rWord;
        sBus = sWord;
      end
    endcase
  end
endmodule

//--- verilog/float_arith_datapath.sv
// Floating point arithmetic unit with three registered buses and feedback
// Assumes the controller drives all inputs synchronously to core_clk
//
// Operation
// - Eight instructions: add, subtract, multiply among them
// - Two-minus-S instruction for reciprocal iteration
// - Convert between float and 32-bit integer
// - Convert between standard and alternate float formats
// - Sign, 8-bit biased exponent, hidden-one significand
// - Selected format governs encoding and handling
// - Four standard rounding modes plus alternate mode
// - Combinational unit, 24x24 multiplier, no pipeline
// - Six status flags per operation
// - Invalid when result has no meaning
// - Underflow and overflow on unrepresentable magnitude
// - Rounded flag when result is not exact
// - Zero and not-numeric result flags
// - Two operand buses, three-state result, feedback
// - Each bus register has own clock enable
// - Each register independently transparent
// - R source mux: result or R bus
// - S operand mux: S register or F register
// - Dual-bus mode uses independent 32-bit buses
// - Single-bus mode alternates R and S operands
// - Half mode moves 16-bit halves per cycle
`timescale 1ns/1ps
module float_arith_datapath (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [31:0] rBus,
  input wire logic [31:0] sBus,
  input wire logic [2:0] opcode,
  input wire logic [2:0] roundMode,
  input wire logic altFormat,
  input wire logic [1:0] ioMode,
  input wire logic rEnable,
  input wire logic sEnable,
  input wire logic fEnable,
  input wire logic rTransparent,
  input wire logic sTransparent,
  input wire logic fTransparent,
  input wire logic rSelectResult,
  input wire logic sSelectF,
  input wire logic fOutputEnable,
  output logic [31:0] fBus,
  output logic fBusEn,
  output logic [5:0] statusFlags,
  output logic halfPhase
);
  logic [31:0] rData_reg;
  logic [31:0] sData_reg;
  logic [31:0] fData_reg;
  logic [5:0] flags_reg;
  logic [15:0] rUpper_reg;
  logic [15:0] sUpper_reg;
  logic phase_reg;
  logic fDrive_reg;
  logic [31:0] result;
  logic [5:0] flagsLive;

  // Pick rounding increment from mode and discarded bits
  function automatic logic roundUp(input logic [2:0] mode, input logic sg, input logic lsb,
                                   input logic rnd, input logic st);
    case (mode)
      float_arith_pkg::RND_NEAREST_EVEN: roundUp = rnd & (st | lsb);
      float_arith_pkg::RND_TOWARD_ZERO: roundUp = 1'b0;
      float_arith_pkg::RND_TOWARD_POS: roundUp = ~sg & (rnd | st);
      float_arith_pkg::RND_TOWARD_NEG: roundUp = sg & (rnd | st);
      float_arith_pkg::RND_ALT_HALF_AWAY: roundUp = rnd;
      default: roundUp = 1'b0;
    endcase
  endfunction

  // Split a word into class, sign, exponent and significand
  function automatic float_arith_pkg::operand_t unpack(input logic alt, input logic [31:0] x);
    float_arith_pkg::operand_t u;
    u.sg = x[31];
    u.sig = {1'b1, x[22:0]};
    u.cls = float_arith_pkg::CLS_NUM;
    u.ex = $signed({4'h0, x[30:23]}) - (alt ? float_arith_pkg::ALT_BIAS : float_arith_pkg::STD_BIAS);
    if (alt && x[30:23] == 8'h00)
    begin
      u.cls = x[31] ? float_arith_pkg::CLS_NAN : float_arith_pkg::CLS_ZERO;
      u.sig = 24'h00_0000;
    end
    else if (!alt && x[30:23] == 8'h00)
    begin
      u.ex = float_arith_pkg::STD_DENORM_EXP;
      u.sig = {1'b0, x[22:0]};
      if (x[22:0] == 23'h00_0000)
        u.cls = float_arith_pkg::CLS_ZERO;
    end
    else if (!alt && x[30:23] == float_arith_pkg::EXP_ALL_ONES)
      u.cls = (x[22:0] == 23'h00_0000) ? float_arith_pkg::CLS_INF : float_arith_pkg::CLS_NAN;
    return u;
  endfunction

  // Normalise, round and pack; returns {underflow, overflow, rounded, word}
  function automatic logic [34:0] packRound(input logic alt, input logic [2:0] mode, input logic sg,
                                            input logic signed [11:0] ex, input logic [63:0] w);
    logic [5:0] lz;
    logic [63:0] n;
    logic [63:0] d;
    logic [5:0] dn;
    logic signed [11:0] be;
    logic [24:0] m;
    logic st;
    logic nx;
    logic tiny;
    logic toInf;
    logic [31:0] res;
    lz = 6'd0;
    for (int i = 0; i < 64; i++)
      if (w[i])
        lz = 6'(63 - i);
    n = w << lz;
    be = ex + 12'sd1 - $signed({6'h00, lz}) + (alt ? float_arith_pkg::ALT_BIAS : float_arith_pkg::STD_BIAS);
    tiny = (be < 12'sd1);
    dn = 6'd0;
    if (tiny && !alt)
      dn = (be < -12'sd62) ? 6'd63 : 6'(12'sd1 - be);
    d = n >> dn;
    st = (|d[38:0]) | ((d << dn) != n);
    m = {1'b0, d[63:40]} + 25'(roundUp(mode, sg, d[40], d[39], st));
    nx = d[39] | st;
    if (m[24])
    begin
      m = m >> 1;
      be = be + 12'sd1;
    end
    toInf = (mode == float_arith_pkg::RND_NEAREST_EVEN) || (mode == float_arith_pkg::RND_ALT_HALF_AWAY)
            || (mode == float_arith_pkg::RND_TOWARD_POS && !sg) || (mode == float_arith_pkg::RND_TOWARD_NEG && sg);
    res = {sg, be[7:0], m[22:0]};
    packRound = {2'b00, nx, res};
    if (w == 64'h0000_0000_0000_0000)
      packRound = {3'b000, alt ? float_arith_pkg::WORD_RESET : {sg, 31'h0000_0000}};
    else if (be > (alt ? 12'sd255 : 12'sd254))
      packRound = {2'b01, 1'b1, (toInf && !alt) ? {sg, float_arith_pkg::EXP_ALL_ONES, 23'h00_0000}
                                                : {sg, 8'hFE + 8'(alt), 23'h7F_FFFF}};
    else if (tiny && alt)
      packRound = {3'b101, float_arith_pkg::WORD_RESET};
    else if (tiny)
      packRound = {nx, 1'b0, nx, sg, 7'h00, m[23], m[22:0]};
  endfunction

  // Arithmetic unit: purely combinational, result in the same cycle
  logic [31:0] rWord;
  logic [31:0] sWord;
  logic [31:0] rOperand;
  logic [31:0] sOperand;
  logic outAlt;
  logic intResult;
  always_comb
  begin
    float_arith_pkg::operand_t ua;
    float_arith_pkg::operand_t ub;
    float_arith_pkg::operand_t big;
    float_arith_pkg::operand_t lesser;
    logic sb;
    logic inv;
    logic nanRes;
    logic [34:0] pr;
    logic [11:0] dd;
    logic [63:0] wb;
    logic [63:0] ws;
    logic [63:0] wsum;
    logic [47:0] prod;
    logic [31:0] mag;
    logic [63:0] x;
    logic [63:0] q;
    logic [63:0] rem;
    logic [6:0] sh;
    logic up;
    ua = unpack(altFormat, rOperand);
    ub = unpack(altFormat, sOperand);
    sb = ub.sg ^ (opcode != float_arith_pkg::OP_ADD);
    inv = 1'b0;
    nanRes = 1'b0;
    pr = 35'h0_0000_0000;
    big = ua;
    lesser = ub;
    dd = 12'h000;
    wb = 64'h0;
    ws = 64'h0;
    wsum = 64'h0;
    prod = 48'h0;
    mag = 32'h0;
    x = 64'h0;
    q = 64'h0;
    rem = 64'h0;
    sh = 7'h00;
    up = 1'b0;
    case (opcode)
      float_arith_pkg::OP_ADD, float_arith_pkg::OP_SUB, float_arith_pkg::OP_TWO_MINUS:
      begin
        if (opcode == float_arith_pkg::OP_TWO_MINUS)
          ua = '{float_arith_pkg::CLS_NUM, 1'b0, 12'sd1, float_arith_pkg::SIG_ONE};
        ub.sg = sb;
        if (ua.cls == float_arith_pkg::CLS_NAN || ub.cls == float_arith_pkg::CLS_NAN)
        begin
          nanRes = 1'b1;
          inv = altFormat | (ua.cls == float_arith_pkg::CLS_NAN && !ua.sig[22])
                | (ub.cls == float_arith_pkg::CLS_NAN && !ub.sig[22]);
        end
        else if (ua.cls == float_arith_pkg::CLS_INF && ub.cls == float_arith_pkg::CLS_INF && ua.sg != ub.sg)
        begin
          nanRes = 1'b1;
          inv = 1'b1;
        end
        else if (ua.cls == float_arith_pkg::CLS_INF || ub.cls == float_arith_pkg::CLS_INF)
          pr[31:0] = {(ua.cls == float_arith_pkg::CLS_INF) ? ua.sg : ub.sg, float_arith_pkg::EXP_ALL_ONES, 23'h0};
        else
        begin
          // Align the smaller operand, keep a sticky bit, then add or subtract
          if (ub.ex > ua.ex || (ub.ex == ua.ex && ub.sig > ua.sig))
          begin
            big = ub;
            lesser = ua;
          end
          else
          begin
            big = ua;
            lesser = ub;
          end
          dd = 12'(big.ex - lesser.ex);
          wb = {1'b0, big.sig, 39'h0};
          ws = {1'b0, lesser.sig, 39'h0};
          if (dd > 12'd63)
            ws = {63'h0, |lesser.sig};
          else if (((ws >> dd) << dd) != ws)
            ws = (ws >> dd) | 64'h1;
          else
            ws = ws >> dd;
          wsum = (big.sg == lesser.sg) ? wb + ws : wb - ws;
          pr = packRound(altFormat, roundMode, (wsum == 64'h0 && big.sg != lesser.sg)
                         ? (roundMode == float_arith_pkg::RND_TOWARD_NEG) : big.sg, big.ex, wsum);
        end
      end
      float_arith_pkg::OP_MUL:
      begin
        if (ua.cls == float_arith_pkg::CLS_NAN || ub.cls == float_arith_pkg::CLS_NAN)
        begin
          nanRes = 1'b1;
          inv = altFormat | (ua.cls == float_arith_pkg::CLS_NAN && !ua.sig[22])
                | (ub.cls == float_arith_pkg::CLS_NAN && !ub.sig[22]);
        end
        else if ((ua.cls == float_arith_pkg::CLS_INF && ub.cls == float_arith_pkg::CLS_ZERO)
                 || (ub.cls == float_arith_pkg::CLS_INF && ua.cls == float_arith_pkg::CLS_ZERO))
        begin
          nanRes = 1'b1;
          inv = 1'b1;
        end
        else if (ua.cls == float_arith_pkg::CLS_INF || ub.cls == float_arith_pkg::CLS_INF)
          pr[31:0] = {ua.sg ^ ub.sg, float_arith_pkg::EXP_ALL_ONES, 23'h0};
        else
        begin
          prod = ua.sig * ub.sig;
          pr = packRound(altFormat, roundMode, ua.sg ^ ub.sg, ua.ex + ub.ex, {prod, 16'h0000});
        end
      end
      float_arith_pkg::OP_INTEGER_TO_FLOAT:
      begin
        mag = rOperand[31] ? 32'(-rOperand) : rOperand;
        pr = packRound(altFormat, roundMode, rOperand[31], 12'sd30, {mag, 32'h0});
      end
      float_arith_pkg::OP_FLOAT_TO_INTEGER:
      begin
        if (ua.cls == float_arith_pkg::CLS_NAN || ua.cls == float_arith_pkg::CLS_INF || ua.ex > 12'sd30)
        begin
          inv = !(ua.cls == float_arith_pkg::CLS_NUM && ua.sg && ua.ex == 12'sd31
                  && ua.sig == float_arith_pkg::SIG_ONE);
          pr[31:0] = (ua.sg && ua.cls != float_arith_pkg::CLS_NAN) ? float_arith_pkg::INT_MIN_NEG
                                                                    : float_arith_pkg::INT_MAX_POS;
        end
        else if (ua.cls == float_arith_pkg::CLS_NUM)
        begin
          // Integer part, round bit and sticky from a shifted significand
          x = {ua.sig, 40'h0};
          if (ua.ex < -12'sd1)
            rem = 64'h1;
          else
          begin
            sh = 7'(12'sd63 - ua.ex);
            q = x >> sh;
            rem = x << (7'd64 - sh);
          end
          up = roundUp(roundMode, ua.sg, q[0], rem[63], |rem[62:0]);
          mag = q[31:0] + 32'(up);
          inv = mag[31] && !(ua.sg && mag == float_arith_pkg::INT_MIN_NEG);
          pr = {2'b00, |rem, inv ? (ua.sg ? float_arith_pkg::INT_MIN_NEG : float_arith_pkg::INT_MAX_POS)
                                 : (ua.sg ? 32'(-mag) : mag)};
        end
      end
      float_arith_pkg::OP_STD_TO_ALT_FORMAT, float_arith_pkg::OP_ALT_TO_STD_FORMAT:
      begin
        ua = unpack(opcode == float_arith_pkg::OP_ALT_TO_STD_FORMAT, rOperand);
        if (ua.cls == float_arith_pkg::CLS_NAN || ua.cls == float_arith_pkg::CLS_INF)
        begin
          nanRes = 1'b1;
          inv = 1'b1;
        end
        else
          pr = packRound(opcode == float_arith_pkg::OP_STD_TO_ALT_FORMAT, roundMode, ua.sg, ua.ex,
                         {1'b0, ua.sig, 39'h0});
      end
      default: pr = 35'h0_0000_0000;
    endcase
    result = nanRes ? (outAlt ? float_arith_pkg::ALT_RESERVED : float_arith_pkg::STD_QUIET_NAN) : pr[31:0];
    flagsLive[float_arith_pkg::FLAG_INVALID] = inv;
    flagsLive[float_arith_pkg::FLAG_UNDERFLOW] = pr[34] & !nanRes;
    flagsLive[float_arith_pkg::FLAG_OVERFLOW] = pr[33] & !nanRes;
    flagsLive[float_arith_pkg::FLAG_ROUNDED] = pr[32] & !nanRes;
    flagsLive[float_arith_pkg::FLAG_ZERO] = intResult ? (result == 32'h0)
                                            : (outAlt ? result[31:23] == 9'h000 : result[30:0] == 31'h0);
    flagsLive[float_arith_pkg::FLAG_NOT_NUMERIC] = !intResult && (outAlt
      ? (result[31] && result[30:23] == 8'h00)
      : (result[30:23] == float_arith_pkg::EXP_ALL_ONES && result[22:0] != 23'h0));
  end

  // Result encoding follows the destination format
  assign intResult = (opcode == float_arith_pkg::OP_FLOAT_TO_INTEGER);
  assign outAlt = (opcode == float_arith_pkg::OP_STD_TO_ALT_FORMAT)
                  || (altFormat && opcode != float_arith_pkg::OP_ALT_TO_STD_FORMAT);

  // Bus word assembly and load slots per I/O mode
  logic dualMode;
  logic singleMode;
  logic halfMode;
  logic rLoad;
  logic sLoad;
  logic fLoad;
  logic [31:0] rNext;
  assign dualMode = (ioMode == float_arith_pkg::IO_DUAL32);
  assign singleMode = (ioMode == float_arith_pkg::IO_SINGLE32);
  assign halfMode = (ioMode == float_arith_pkg::IO_HALF16);
  assign rWord = halfMode ? {rUpper_reg, rBus[15:0]} : rBus;
  assign sWord = halfMode ? {sUpper_reg, sBus[15:0]} : (singleMode ? rBus : sBus);
  assign rLoad = rEnable && (dualMode || !phase_reg);
  assign sLoad = sEnable && (dualMode || (singleMode ? phase_reg : !phase_reg));
  assign fLoad = fEnable && !(halfMode && phase_reg);
  assign rNext = rSelectResult ? result : rWord;

  // Operand and output selection, with transparency bypass
  logic [31:0] sRegView;
  logic [31:0] fValue;
  assign rOperand = rTransparent ? rWord : rData_reg;
  assign sRegView = sTransparent ? sWord : sData_reg;
  assign sOperand = sSelectF ? fData_reg : sRegView;
  assign fValue = fTransparent ? result : fData_reg;
  assign fBus = halfMode ? {16'h0000, phase_reg ? fValue[31:16] : fValue[15:0]} : fValue;
  assign statusFlags = fTransparent ? flagsLive : flags_reg;
  assign fBusEn = fDrive_reg;
  assign halfPhase = phase_reg;

  // Phase of the multiplexed bus modes
  always_ff @(posedge core_clk)
  begin
    if (reset || dualMode)
      phase_reg <= 1'b1;
    else
      phase_reg <= !phase_reg;
  end

  // Upper halves captured in the first phase
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rUpper_reg <= 16'h0000;
      sUpper_reg <= 16'h0000;
    end
    else if (halfMode && phase_reg)
    begin
      rUpper_reg <= rBus[15:0];
      sUpper_reg <= sBus[15:0];
    end
  end

  // Operand registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rData_reg <= float_arith_pkg::WORD_RESET;
      sData_reg <= float_arith_pkg::WORD_RESET;
    end
    else
    begin
      if (rLoad)
        rData_reg <= rNext;
      if (sLoad)
        sData_reg <= sWord;
    end
  end

  // Result register, flags and output drive
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      fData_reg <= float_arith_pkg::WORD_RESET;
      flags_reg <= float_arith_pkg::FLAGS_RESET;
      fDrive_reg <= 1'b0;
    end
    else
    begin
      fDrive_reg <= fOutputEnable;
      if (fLoad)
      begin
        fData_reg <= result;
        flags_reg <= flagsLive;
      end
    end
  end
endmodule

//--- verilog/float_arith_pkg.sv
// Constants, encodings and operand layout for the floating point datapath
// Shared by the datapath module and the bench; no logic here
package float_arith_pkg;
  // Arithmetic unit instructions
  typedef enum logic [2:0] {
    OP_ADD = 3'b000,
    OP_SUB = 3'b001,
    OP_MUL = 3'b010,
    OP_TWO_MINUS = 3'b011,
    OP_INTEGER_TO_FLOAT = 3'b100,
    OP_FLOAT_TO_INTEGER = 3'b101,
    OP_STD_TO_ALT_FORMAT = 3'b110,
    OP_ALT_TO_STD_FORMAT = 3'b111
  } opcode_t;
  // Rounding modes; the last one is for the alternate format
  typedef enum logic [2:0] {
    RND_NEAREST_EVEN = 3'b000,
    RND_TOWARD_ZERO = 3'b001,
    RND_TOWARD_POS = 3'b010,
    RND_TOWARD_NEG = 3'b011,
    RND_ALT_HALF_AWAY = 3'b100
  } round_mode_t;
  // Bus width modes
  typedef enum logic [1:0] {
    IO_DUAL32 = 2'b00,
    IO_SINGLE32 = 2'b01,
    IO_HALF16 = 2'b10
  } io_mode_t;
  // Operand classes after unpacking
  typedef enum logic [1:0] {
    CLS_NUM = 2'b00,
    CLS_ZERO = 2'b01,
    CLS_INF = 2'b10,
    CLS_NAN = 2'b11
  } op_class_t;
  // Unpacked operand: value is sig * 2^(ex-23)
  typedef struct packed {
    op_class_t cls;
    logic sg;
    logic signed [11:0] ex;
    logic [23:0] sig;
  } operand_t;
  // Status flag positions
  localparam int FLAG_INVALID = 5;
  localparam int FLAG_UNDERFLOW = 4;
  localparam int FLAG_OVERFLOW = 3;
  localparam int FLAG_ROUNDED = 2;
  localparam int FLAG_ZERO = 1;
  localparam int FLAG_NOT_NUMERIC = 0;
  // Format constants
  localparam logic signed [11:0] STD_BIAS = 12'sh07F;
  localparam logic signed [11:0] ALT_BIAS = 12'sh081;
  localparam logic signed [11:0] STD_DENORM_EXP = -12'sh07E;
  localparam logic [7:0] EXP_ALL_ONES = 8'hFF;
  localparam logic [31:0] STD_QUIET_NAN = 32'h7FC0_0000;
  localparam logic [31:0] ALT_RESERVED = 32'h8000_0000;
  localparam logic [31:0] INT_MAX_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] INT_MIN_NEG = 32'h8000_0000;
  localparam logic [23:0] SIG_ONE = 24'h80_0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
endpackage
